// File: core/auto_reload_timer_control.sv
// Wishbone register front end, flags and interrupt logic of the auto-reload timer.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module auto_reload_timer_control (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave.
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Low-frequency oscillator output, asynchronous.
    input  wire logic        lfo_i,
    // Interrupt request to the processor.
    output logic             irq_o
);
    count_if cif ();

    logic                           ack_r;
    logic [31:0]                    dat_r;
    logic                           high_flag_r;
    logic                           low_flag_r;
    logic                           low_overflow_irq_enable_r;
    logic                           lfo_capture_enable_r;
    logic                           split_mode_enable_r;
    logic                           run_control_r;
    logic [timer_pkg::IRQ_W-1:0]    stat_r;
    logic [timer_pkg::IRQ_W-1:0]    mask_r;
    logic                           timer_irq_en_r;
    logic                           high_flag_nxt;
    logic                           low_flag_nxt;
    logic [timer_pkg::IRQ_W-1:0]    stat_nxt;

    wire                            bus_req;
    wire                            bus_wr;
    wire [7:0]                      word_adr;
    wire                            hit_ctrl;
    wire                            hit_count;
    wire                            hit_reload;
    wire                            hit_stat;
    wire                            hit_mask;
    wire                            hit_ie;
    wire                            wr_ctrl;
    wire                            clr_high;
    wire                            clr_low;
    wire                            lfo_fall;
    wire                            cap_event;
    wire [timer_pkg::IRQ_W-1:0]     stat_set;
    wire [timer_pkg::IRQ_W-1:0]     stat_clr;
    wire [7:0]                      ctrl_rd;
    wire [31:0]                     rd_mux;

    // Bus decode. Writes take effect on the edge at which ack is high.
    assign bus_req    = cyc_i & stb_i;
    assign bus_wr     = bus_req & we_i & ack_r;
    assign word_adr   = {adr_i[7:2], 2'b00};
    assign hit_ctrl   = word_adr == timer_pkg::CTRL_OFF;
    assign hit_count  = word_adr == timer_pkg::COUNT_OFF;
    assign hit_reload = word_adr == timer_pkg::RELOAD_OFF;
    assign hit_stat   = word_adr == timer_pkg::STAT_OFF;
    assign hit_mask   = word_adr == timer_pkg::MASK_OFF;
    assign hit_ie     = word_adr == timer_pkg::TIMER_IE_OFF;
    assign wr_ctrl    = bus_wr & hit_ctrl & sel_i[0];

    // Writing zero to a flag clears it; writing one leaves it alone.
    assign clr_high = wr_ctrl & ~dat_i[timer_pkg::HIGH_FLAG_BIT];
    assign clr_low  = wr_ctrl & ~dat_i[timer_pkg::LOW_FLAG_BIT];

    // Counter datapath controls.
    assign cif.run       = run_control_r;
    assign cif.split     = split_mode_enable_r;
    assign cif.cnt_we_lo = bus_wr & hit_count & sel_i[0];
    assign cif.cnt_we_hi = bus_wr & hit_count & sel_i[1];
    assign cif.rld_we_lo = bus_wr & hit_reload & sel_i[0];
    assign cif.rld_we_hi = bus_wr & hit_reload & sel_i[1];
    assign cif.wdata     = dat_i[15:0];
    assign cap_event     = lfo_fall & lfo_capture_enable_r;
    assign cif.capture   = cap_event;

    // Hardware sets take priority over the software clear.
    assign high_flag_nxt = cif.high_ovf | (high_flag_r & ~clr_high);
    assign low_flag_nxt  = cif.low_ovf | (low_flag_r & ~clr_low);

    // Interrupt events; status bits are write-one-to-clear.
    assign stat_set[timer_pkg::IRQ_HIGH_BIT] = cif.high_ovf;
    assign stat_set[timer_pkg::IRQ_LOW_BIT]  = cif.low_ovf & low_overflow_irq_enable_r;
    assign stat_set[timer_pkg::IRQ_CAP_BIT]  = cap_event;
    assign stat_clr = (bus_wr & hit_stat & sel_i[0]) ? dat_i[timer_pkg::IRQ_W-1:0] : 3'h0;
    assign stat_nxt = stat_set | (stat_r & ~stat_clr);

    // The global timer enable keeps every source quiet while it is low.
    assign irq_o = timer_irq_en_r & |(stat_r & mask_r);

    // Read side. Bits 1 and 0 read as zero.
    assign ctrl_rd = {high_flag_r, low_flag_r, low_overflow_irq_enable_r,
                      lfo_capture_enable_r, split_mode_enable_r, run_control_r, 2'b00};
    assign rd_mux  = hit_ctrl   ? {24'h000000, ctrl_rd} :
                     hit_count  ? {16'h0000, cif.count} :
                     hit_reload ? {16'h0000, cif.reload} :
                     hit_stat   ? {29'h0000000, stat_r} :
                     hit_mask   ? {29'h0000000, mask_r} :
                     hit_ie     ? {31'h0000000, timer_irq_en_r} :
                     32'h00000000;

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // The oscillator runs from its own source, so it enters only through the synchroniser.
    lfo_edge_sync u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .lfo_i  (lfo_i),
        .fall_o (lfo_fall)
    );

    reload_counter u_count (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cif   (cif)
    );

    // Bus handshake: ack one cycle after the request, dropped the next cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= bus_req & ~ack_r;
            dat_r <= (bus_req & ~ack_r & ~we_i) ? rd_mux : 32'h00000000;
        end
    end

    // Flags and interrupt status.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_flag_r <= timer_pkg::CTRL_RST[timer_pkg::HIGH_FLAG_BIT];
            low_flag_r  <= timer_pkg::CTRL_RST[timer_pkg::LOW_FLAG_BIT];
            stat_r      <= timer_pkg::IRQ_RST;
        end else begin
            high_flag_r <= high_flag_nxt;
            low_flag_r  <= low_flag_nxt;
            stat_r      <= stat_nxt;
        end
    end

    // Software-owned control bits.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_overflow_irq_enable_r <= timer_pkg::CTRL_RST[timer_pkg::LOW_IRQ_EN_BIT];
            lfo_capture_enable_r      <= timer_pkg::CTRL_RST[timer_pkg::CAP_EN_BIT];
            split_mode_enable_r       <= timer_pkg::CTRL_RST[timer_pkg::SPLIT_BIT];
            run_control_r             <= timer_pkg::CTRL_RST[timer_pkg::RUN_BIT];
        end else if (wr_ctrl) begin
            low_overflow_irq_enable_r <= dat_i[timer_pkg::LOW_IRQ_EN_BIT];
            lfo_capture_enable_r      <= dat_i[timer_pkg::CAP_EN_BIT];
            split_mode_enable_r       <= dat_i[timer_pkg::SPLIT_BIT];
            run_control_r             <= dat_i[timer_pkg::RUN_BIT];
        end
    end

    // Interrupt mask and global timer interrupt enable.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r         <= timer_pkg::IRQ_RST;
            timer_irq_en_r <= 1'b0;
        end else begin
            if (bus_wr & hit_mask & sel_i[0]) begin
                mask_r <= dat_i[timer_pkg::IRQ_W-1:0];
            end
            if (bus_wr & hit_ie & sel_i[0]) begin
                timer_irq_en_r <= dat_i[0];
            end
        end
    end

    // Checks sample on the system clock and rest while reset is high.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_bus_quiet;
        !bus_wr;
    endsequence

    sequence s_high_event_enabled;
        cif.high_ovf && timer_irq_en_r && mask_r[timer_pkg::IRQ_HIGH_BIT];
    endsequence

    sequence s_cap_event;
        lfo_fall && lfo_capture_enable_r;
    endsequence

    sequence s_high_clear_race;
        cif.high_ovf && clr_high;
    endsequence

    sequence s_low_clear_race;
        cif.low_ovf && clr_low;
    endsequence

    a_ack_single_pulse: assert property (
        ack_o |=> !ack_o)
        else $error("ack stayed high for more than one cycle");
    a_ack_follows_req: assert property (
        bus_req && !ack_o |=> ack_o)
        else $error("ack did not follow a request by one cycle");
    a_high_flag_set: assert property (
        cif.high_ovf |=> high_flag_r)
        else $error("high overflow did not set the high flag");
    a_high_flag_sticky: assert property (
        high_flag_r && !clr_high |=> high_flag_r)
        else $error("high flag cleared without a software write");
    a_low_flag_set: assert property (
        cif.low_ovf |=> low_flag_r)
        else $error("low overflow did not set the low flag");
    a_low_flag_sticky: assert property (
        low_flag_r && !clr_low |=> low_flag_r)
        else $error("low flag cleared without a software write");
    a_set_beats_clear: assert property (
        s_high_clear_race |=> high_flag_r)
        else $error("software clear won over a hardware set");
    a_high_irq_raised: assert property (
        s_high_event_enabled ##0 s_bus_quiet |=> irq_o)
        else $error("enabled high overflow raised no interrupt");
    a_low_irq_gated: assert property (
        cif.low_ovf && !low_overflow_irq_enable_r && !stat_r[timer_pkg::IRQ_LOW_BIT]
        |=> !stat_r[timer_pkg::IRQ_LOW_BIT])
        else $error("low overflow interrupt latched while its enable was low");
    a_capture_irq: assert property (
        s_cap_event |=> stat_r[timer_pkg::IRQ_CAP_BIT])
        else $error("oscillator falling edge did not latch a capture interrupt");
    a_capture_off: assert property (
        !lfo_capture_enable_r |-> !cif.capture)
        else $error("capture fired while capture was disabled");
    a_irq_off_when_disabled: assert property (
        !timer_irq_en_r |-> !irq_o)
        else $error("interrupt raised while timer interrupts were disabled");

    // A stale word on the read bus could be taken by a master that samples late.
    a_read_idle_zero: assert property (
        !ack_o |-> dat_o == 32'h00000000)
        else $error("read data not zero outside an acknowledge");
    a_run_written: assert property (
        wr_ctrl |=> run_control_r == $past(dat_i[timer_pkg::RUN_BIT]))
        else $error("run control did not take the written value");
    a_split_written: assert property (
        wr_ctrl |=> split_mode_enable_r == $past(dat_i[timer_pkg::SPLIT_BIT]))
        else $error("split mode did not take the written value");

    // A flag that cannot be cleared would read back as set in the control byte for good.
    a_high_flag_clear: assert property (
        clr_high && !cif.high_ovf |=> !high_flag_r)
        else $error("software clear of the high flag had no effect");
    a_low_flag_clear: assert property (
        clr_low && !cif.low_ovf |=> !low_flag_r)
        else $error("software clear of the low flag had no effect");
    a_low_set_beats_clear: assert property (
        s_low_clear_race |=> low_flag_r)
        else $error("software clear won over a low overflow");

    // Status bits latch every enabled event, whatever the mask holds.
    a_high_stat_set: assert property (
        cif.high_ovf |=> stat_r[timer_pkg::IRQ_HIGH_BIT])
        else $error("high overflow did not latch its status bit");
    a_low_stat_set: assert property (
        cif.low_ovf && low_overflow_irq_enable_r |=> stat_r[timer_pkg::IRQ_LOW_BIT])
        else $error("enabled low overflow did not latch its status bit");
    a_stat_set_wins: assert property (
        cif.high_ovf && stat_clr[timer_pkg::IRQ_HIGH_BIT] |=> stat_r[timer_pkg::IRQ_HIGH_BIT])
        else $error("status clear won over a high overflow");
    a_cap_stat_sticky: assert property (
        stat_r[timer_pkg::IRQ_CAP_BIT] && !stat_clr[timer_pkg::IRQ_CAP_BIT]
        |=> stat_r[timer_pkg::IRQ_CAP_BIT])
        else $error("capture status bit dropped without a clear");
    a_low_irq_raised: assert property (
        stat_r[timer_pkg::IRQ_LOW_BIT] && mask_r[timer_pkg::IRQ_LOW_BIT] && timer_irq_en_r
        |-> irq_o)
        else $error("enabled low status raised no interrupt");
    a_cap_irq_raised: assert property (
        stat_r[timer_pkg::IRQ_CAP_BIT] && mask_r[timer_pkg::IRQ_CAP_BIT] && timer_irq_en_r
        |-> irq_o)
        else $error("enabled capture status raised no interrupt");
    a_irq_needs_status: assert property (
        irq_o |-> |(stat_r & mask_r))
        else $error("interrupt raised with no unmasked status bit");
endmodule

// File: include/timer_pkg.sv
// Register map, field positions and reset values of the auto-reload timer.
package timer_pkg;

    // Byte addresses of the 32-bit register words.
    localparam logic [7:0] CTRL_OFF    = 8'hC8;
    localparam logic [7:0] COUNT_OFF   = 8'hCC;
    localparam logic [7:0] RELOAD_OFF  = 8'hD0;
    localparam logic [7:0] STAT_OFF    = 8'hD4;
    localparam logic [7:0] MASK_OFF    = 8'hD8;
    localparam logic [7:0] TIMER_IE_OFF = 8'hDC;

    // Field positions in the control and status byte.
    localparam int HIGH_FLAG_BIT  = 7;
    localparam int LOW_FLAG_BIT   = 6;
    localparam int LOW_IRQ_EN_BIT = 5;
    localparam int CAP_EN_BIT     = 4;
    localparam int SPLIT_BIT      = 3;
    localparam int RUN_BIT        = 2;

    // Field positions in the interrupt status and mask words.
    localparam int IRQ_HIGH_BIT = 0;
    localparam int IRQ_LOW_BIT  = 1;
    localparam int IRQ_CAP_BIT  = 2;
    localparam int IRQ_W        = 3;

    // Reset values.
    localparam logic [7:0]       CTRL_RST   = 8'h00;
    localparam logic [15:0]      COUNT_RST  = 16'h0000;
    localparam logic [15:0]      RELOAD_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RST    = 3'h0;

    // Byte values at which a count byte rolls over.
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] BYTE_MIN = 8'h00;

endpackage

// File: include/count_if.sv
// Signals between the register front end and the counter datapath.
`timescale 1ns/1ps
interface count_if;
    logic        run;
    logic        split;
    logic        cnt_we_lo;
    logic        cnt_we_hi;
    logic        rld_we_lo;
    logic        rld_we_hi;
    logic [15:0] wdata;
    logic        capture;
    logic [15:0] count;
    logic [15:0] reload;
    logic        low_ovf;
    logic        high_ovf;

    modport ctrl (
        output run, split, cnt_we_lo, cnt_we_hi, rld_we_lo, rld_we_hi, wdata, capture,
        input  count, reload, low_ovf, high_ovf
    );
    modport core (
        input  run, split, cnt_we_lo, cnt_we_hi, rld_we_lo, rld_we_hi, wdata, capture,
        output count, reload, low_ovf, high_ovf
    );
endinterface

// File: core/lfo_edge_sync.sv
// Two-stage synchroniser and falling-edge detector for the oscillator input.
`timescale 1ns/1ps
module lfo_edge_sync (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Asynchronous oscillator level and its falling-edge pulse.
    input  wire logic lfo_i,
    output logic      fall_o
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // Only the second stage reads the first, so metastability cannot leak.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= lfo_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign fall_o = last_r & ~sync_r;
endmodule

// File: core/reload_counter.sv
// Counter datapath: one 16-bit or two 8-bit auto-reload counters plus reload bytes.
`timescale 1ns/1ps
module reload_counter (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control and results.
    count_if.core     cif
);
    logic [7:0] lo_r;
    logic [7:0] hi_r;
    logic [7:0] rl_lo_r;
    logic [7:0] rl_hi_r;
    logic [7:0] lo_nxt;
    logic [7:0] hi_nxt;
    logic       lo_tick;
    logic       hi_tick;
    logic       lo_wrap;
    logic       hi_wrap;
    logic       lo_reload;

    function automatic logic [7:0] inc8(input logic [7:0] v);
        inc8 = v + 8'h01;
    endfunction

    // In split mode the low byte ignores run control.
    assign lo_tick   = cif.split | cif.run;
    assign lo_wrap   = lo_tick & (lo_r == timer_pkg::BYTE_MAX);
    assign hi_tick   = cif.split ? cif.run : (cif.run & lo_wrap);
    assign hi_wrap   = hi_tick & (hi_r == timer_pkg::BYTE_MAX);
    assign lo_reload = cif.split ? lo_wrap : hi_wrap;
    assign lo_nxt    = cif.cnt_we_lo ? cif.wdata[7:0] :
                       lo_reload ? rl_lo_r : lo_tick ? inc8(lo_r) : lo_r;
    assign hi_nxt    = cif.cnt_we_hi ? cif.wdata[15:8] :
                       hi_wrap ? rl_hi_r : hi_tick ? inc8(hi_r) : hi_r;

    assign cif.count    = {hi_r, lo_r};
    assign cif.reload   = {rl_hi_r, rl_lo_r};
    assign cif.low_ovf  = lo_wrap;
    assign cif.high_ovf = hi_wrap;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lo_r    <= timer_pkg::COUNT_RST[7:0];
            hi_r    <= timer_pkg::COUNT_RST[15:8];
            rl_lo_r <= timer_pkg::RELOAD_RST[7:0];
            rl_hi_r <= timer_pkg::RELOAD_RST[15:8];
        end else begin
            lo_r    <= lo_nxt;
            hi_r    <= hi_nxt;
            // A capture wins over a software write to the reload bytes.
            rl_lo_r <= cif.capture ? lo_r : cif.rld_we_lo ? cif.wdata[7:0] : rl_lo_r;
            rl_hi_r <= cif.capture ? hi_r : cif.rld_we_hi ? cif.wdata[15:8] : rl_hi_r;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_capture_copies_count: assert property (
        cif.capture |=> cif.reload == $past(cif.count))
        else $error("capture did not copy the count into the reload bytes");
    a_full_wrap_reload: assert property (
        !cif.split && cif.run && cif.count == 16'hFFFF && !cif.cnt_we_lo && !cif.cnt_we_hi
        |=> cif.count == $past(cif.reload))
        else $error("16-bit wrap did not reload both bytes");
    a_split_low_free: assert property (
        cif.split && !cif.run && !cif.cnt_we_lo && !cif.cnt_we_hi && lo_r != 8'hFF
        |=> lo_r == $past(lo_r) + 8'h01 && hi_r == $past(hi_r))
        else $error("split mode low byte stalled or high byte moved without run");
    a_stopped_holds: assert property (
        !cif.split && !cif.run && !cif.cnt_we_lo && !cif.cnt_we_hi [*2]
        |-> cif.count == $past(cif.count))
        else $error("counter moved while stopped in 16-bit mode");
endmodule

// File: tb/auto_reload_timer_control_test.sv
// Self-checking bench for the auto-reload timer register block.
`timescale 1ns/1ps
module auto_reload_timer_control_test;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic        lfo_i = 1'b1;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        irq_o;
    int          error_cnt = 0;
    int          n_tests   = 0;
    int          cycles    = 0;
    logic [31:0] q;
    logic [31:0] c;
    logic [7:0]  r;
    logic [15:0] v;

    auto_reload_timer_control DUT (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cyc_i (cyc_i),
        .stb_i (stb_i),
        .we_i  (we_i),
        .adr_i (adr_i),
        .sel_i (sel_i),
        .dat_i (dat_i),
        .dat_o (dat_o),
        .ack_o (ack_o),
        .lfo_i (lfo_i),
        .irq_o (irq_o)
    );

    always #4 clk_i = ~clk_i;

    // The ceiling is several times the length of the planned sequence.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t timeout", $time);
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Expected control byte built from its fields.
    function automatic logic [31:0] ctrl_val(input int hf, input int lf, input int lie,
                                             input int cen, input int spl, input int run);
        ctrl_val = 32'h00000000;
        ctrl_val[timer_pkg::HIGH_FLAG_BIT]  = hf[0];
        ctrl_val[timer_pkg::LOW_FLAG_BIT]   = lf[0];
        ctrl_val[timer_pkg::LOW_IRQ_EN_BIT] = lie[0];
        ctrl_val[timer_pkg::CAP_EN_BIT]     = cen[0];
        ctrl_val[timer_pkg::SPLIT_BIT]      = spl[0];
        ctrl_val[timer_pkg::RUN_BIT]        = run[0];
    endfunction

    // Classic single cycle; the request is held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        // A lost acknowledge is caught by the bench timeout.
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        wb(1'b1, a, 4'h3, d, dummy);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] got;
        wb(1'b0, a, 4'hF, 32'h00000000, got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_irq(input logic exp, input string msg);
        @(negedge clk_i);
        n_tests = n_tests + 1;
        if (irq_o !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t irq %s", $time, msg);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic fall_lfo();
        @(posedge clk_i);
        lfo_i <= 1'b1;
        idle(4);
        lfo_i <= 1'b0;
        idle(8);
    endtask

    initial begin
        void'($urandom(52679));
        idle(20);
        rst_i <= 1'b0;
        idle(1);
        chk_reg(timer_pkg::CTRL_OFF, 32'h00000000, "ctrl reset");
        chk_reg(timer_pkg::COUNT_OFF, 32'h00000000, "count reset");
        chk_reg(timer_pkg::RELOAD_OFF, 32'h00000000, "reload reset");
        chk_reg(timer_pkg::STAT_OFF, 32'h00000000, "stat reset");
        chk_reg(timer_pkg::MASK_OFF, 32'h00000000, "mask reset");
        chk_reg(timer_pkg::TIMER_IE_OFF, 32'h00000000, "ie reset");
        wr(8'hE0, 32'h000000FF);
        chk_reg(8'hE0, 32'h00000000, "unmapped");
        chk_irq(1'b0, "after reset");
        $display("test reset done");

        // A random start near the top wraps the full count within 256 ticks.
        r = 8'($urandom_range(0, 240));
        wr(timer_pkg::RELOAD_OFF, 32'h00001234);
        wr(timer_pkg::COUNT_OFF, {16'h0000, 8'hFF, r});
        wr(timer_pkg::CTRL_OFF, ctrl_val(0, 0, 0, 0, 0, 1));
        idle(300);
        wr(timer_pkg::CTRL_OFF, ctrl_val(1, 1, 0, 0, 0, 0));
        chk_reg(timer_pkg::CTRL_OFF, ctrl_val(1, 1, 0, 0, 0, 0), "wrap flags");
        chk_reg(timer_pkg::STAT_OFF, 32'h00000001, "stat low off");
        wb(1'b0, timer_pkg::COUNT_OFF, 4'hF, 32'h00000000, c);
        idle(40);
        chk_reg(timer_pkg::COUNT_OFF, c, "stopped count");
        chk_reg(timer_pkg::CTRL_OFF, ctrl_val(1, 1, 0, 0, 0, 0), "flags stay");
        wr(timer_pkg::CTRL_OFF, ctrl_val(0, 1, 0, 0, 0, 0));
        chk_reg(timer_pkg::CTRL_OFF, ctrl_val(0, 1, 0, 0, 0, 0), "high clear");
        wr(timer_pkg::CTRL_OFF, ctrl_val(0, 0, 0, 0, 0, 0));
        chk_reg(timer_pkg::CTRL_OFF, 32'h00000000, "low clear");
        $display("test wide done");

        wr(timer_pkg::MASK_OFF, 32'h00000001);
        chk_irq(1'b0, "global off");
        wr(timer_pkg::TIMER_IE_OFF, 32'h00000001);
        chk_irq(1'b1, "high irq");
        wr(timer_pkg::MASK_OFF, 32'h00000000);
        chk_irq(1'b0, "masked");
        wr(timer_pkg::MASK_OFF, 32'h00000007);
        wr(timer_pkg::STAT_OFF, 32'h00000001);
        chk_reg(timer_pkg::STAT_OFF, 32'h00000000, "stat w1c");
        chk_irq(1'b0, "cleared");
        $display("test irq done");

        // In split mode with run off only the low byte may move.
        r = 8'($urandom_range(0, 255));
        wr(timer_pkg::COUNT_OFF, {16'h0000, 8'h55, r});
        wr(timer_pkg::RELOAD_OFF, {16'h0000, 8'hF0, 8'($urandom_range(0, 200))});
        wr(timer_pkg::CTRL_OFF, ctrl_val(0, 0, 1, 0, 1, 0));
        idle(300);
        chk_reg(timer_pkg::CTRL_OFF, ctrl_val(0, 1, 1, 0, 1, 0), "split low");
        chk_reg(timer_pkg::STAT_OFF, 32'h00000002, "low stat");
        chk_irq(1'b1, "low irq");
        wb(1'b0, timer_pkg::COUNT_OFF, 4'hF, 32'h00000000, c);
        n_tests = n_tests + 1;
        if (c[15:8] !== 8'h55) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t high byte moved", $time);
        end
        wr(timer_pkg::CTRL_OFF, ctrl_val(0, 1, 1, 0, 1, 1));
        idle(300);
        chk_reg(timer_pkg::CTRL_OFF, ctrl_val(1, 1, 1, 0, 1, 1), "split high");
        wr(timer_pkg::CTRL_OFF, ctrl_val(0, 0, 0, 0, 0, 0));
        wr(timer_pkg::STAT_OFF, 32'h00000007);
        chk_irq(1'b0, "split done");
        $display("test split done");

        // Reloads of 0xFF overflow both halves on every clock, so the stop write meets one.
        wr(timer_pkg::RELOAD_OFF, 32'h0000FFFF);
        wr(timer_pkg::COUNT_OFF, 32'h0000FFFF);
        wr(timer_pkg::CTRL_OFF, ctrl_val(0, 0, 1, 0, 1, 1));
        wr(timer_pkg::CTRL_OFF, ctrl_val(0, 0, 0, 0, 0, 0));
        chk_reg(timer_pkg::CTRL_OFF, ctrl_val(1, 1, 0, 0, 0, 0), "set wins");
        chk_reg(timer_pkg::STAT_OFF, 32'h00000003, "both stat");
        wr(timer_pkg::CTRL_OFF, ctrl_val(0, 0, 0, 0, 0, 0));
        wr(timer_pkg::STAT_OFF, 32'h00000007);
        chk_reg(timer_pkg::CTRL_OFF, 32'h00000000, "stopped clear");
        $display("test race done");

        // Capture from a stopped counter so the expected reload is exact.
        v = 16'($urandom_range(0, 65535));
        wr(timer_pkg::COUNT_OFF, {16'h0000, v});
        wr(timer_pkg::RELOAD_OFF, 32'h0000A5A5);
        fall_lfo();
        chk_reg(timer_pkg::RELOAD_OFF, 32'h0000A5A5, "capture off");
        chk_reg(timer_pkg::STAT_OFF, 32'h00000000, "no capture stat");
        wr(timer_pkg::CTRL_OFF, ctrl_val(0, 0, 0, 1, 0, 0));
        fall_lfo();
        chk_reg(timer_pkg::RELOAD_OFF, {16'h0000, v}, "captured");
        chk_reg(timer_pkg::STAT_OFF, 32'h00000004, "capture stat");
        chk_irq(1'b1, "capture irq");
        $display("test capture done");
        summarize();
    end
endmodule
